/* File: include/ovd_pkg.sv */
// ==========================================================================
// shared widths, reset values and arithmetic for the over-range detector
package ovd_pkg;

  // ========================================================================
  // widths
  localparam int SAMPLE_W = 9;
  localparam int MAG_W = 8;
  localparam int SEL_W = 3;
  localparam int HOLD_LEN_W = 11;
  localparam int HOLD_CNT_W = 10;
  localparam int NUM_CH_MAX = 4;

  // ========================================================================
  // codes and reset values
  localparam logic [SAMPLE_W-1:0] SAMPLE_MOST_NEG = 9'h100;
  localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 9'h000;
  localparam logic [MAG_W-1:0] MAG_MAX = 8'hFF;
  localparam logic [HOLD_CNT_W-1:0] HOLD_CNT_RST = 10'h000;

  // ========================================================================
  // timing: shortest hold, in device clock cycles, scaled by 2**sel
  localparam logic [HOLD_LEN_W-1:0] HOLD_BASE_CYCLES = 11'h008;

  // saturating absolute value; the most negative code has no positive twin
  function automatic logic [MAG_W-1:0] ovd_magnitude(input logic [SAMPLE_W-1:0] s);
    logic [MAG_W-1:0] m;
    if (s == SAMPLE_MOST_NEG)
      m = MAG_MAX;
    else if (s[SAMPLE_W-1])
      m = MAG_W'(~s[MAG_W-1:0] + 8'h01);
    else
      m = s[MAG_W-1:0];
    return m;
  endfunction

  // hold length in cycles for a length select
  function automatic logic [HOLD_LEN_W-1:0] ovd_hold_len(input logic [SEL_W-1:0] sel);
    return HOLD_LEN_W'(HOLD_BASE_CYCLES << sel);
  endfunction

endpackage

/* File: logic/ovd_hold_ctr.sv */
`timescale 1ns/1ps
// ==========================================================================
// per-channel pulse stretcher for one over-range pin
module ovd_hold_ctr
  import ovd_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic detect_enable,
  input wire logic [SEL_W-1:0] hold_length_sel,
  input wire logic hit,
  output logic overrange_out
);

  logic [HOLD_CNT_W-1:0] cnt;
  logic [HOLD_LEN_W-1:0] hold_len;
  logic [HOLD_CNT_W-1:0] next_cnt;
  logic next_out;
  logic cnt_live;

  // ========================================================================
  // next state: every hit reloads, so the pin drops a full length after the last
  assign hold_len = ovd_hold_len(hold_length_sel);
  assign cnt_live = (cnt != HOLD_CNT_RST);
  assign next_cnt = !detect_enable ? HOLD_CNT_RST :
                    hit ? HOLD_CNT_W'(hold_len - 11'h001) : // see [R11]
                    cnt_live ? HOLD_CNT_W'(cnt - 10'h001) : HOLD_CNT_RST; // see [R9]
  assign next_out = detect_enable && (hit || cnt_live); // see [R9]

  // ========================================================================
  // state registers
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      cnt <= HOLD_CNT_RST;
      overrange_out <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      overrange_out <= next_out;
    end
  end

  // ========================================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_short_last_hit;
    (detect_enable && hit && hold_length_sel == 3'h0)
      ##1 (detect_enable && !hit && hold_length_sel == 3'h0) [*8];
  endsequence

  sequence s_long_last_hit;
    (detect_enable && hit && hold_length_sel == 3'h7) ##1 (detect_enable && !hit) [*8];
  endsequence

  a_hold_restart: assert property ( // see [R11]
    (detect_enable && hit) |=> (overrange_out && cnt == HOLD_CNT_W'($past(hold_len) - 11'h001)))
    else $error("hit did not reload the hold counter");

  a_hold_short_expire: assert property ( // see [R9]
    s_short_last_hit |=> !overrange_out)
    else $error("eight-cycle hold did not end on time");

  // only while enable holds; a disable may cut the hold short
  a_hold_short_stays: assert property ( // see [R9]
    (detect_enable && hit && hold_length_sel == 3'h0) ##1 detect_enable [*7]
      |=> (overrange_out && $past(overrange_out, 1) && $past(overrange_out, 2)
           && $past(overrange_out, 3) && $past(overrange_out, 4)
           && $past(overrange_out, 5) && $past(overrange_out, 6)
           && $past(overrange_out, 7)))
    else $error("eight-cycle hold dropped early");

  a_hold_long_stays: assert property ( // see [R9]
    s_long_last_hit |=> overrange_out)
    else $error("long hold dropped early");

endmodule

/* File: logic/ovd_detector.sv */
`timescale 1ns/1ps
// ==========================================================================
// Operation
// [R1] capture each sample on the clock edge
// [R2] samples are 9-bit two's complement codes
// [R3] compare 8-bit absolute magnitude against threshold
// [R4] magnitude saturates: most negative gives 255
// [R5] one threshold shared by every channel
// [R6] detection works only while enable is one
// [R7] magnitude at or above threshold flags channel
// [R8] per-channel pins, unused channels stay low
// [R9] hold pin 8 times 2**sel cycles
// [R10] software sets threshold near full scale
// [R11] new event restarts the channel hold counter
module ovd_detector
  import ovd_pkg::*;
#(
  parameter int NUM_CH = 4
)
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [SAMPLE_W-1:0] sample_ch_a,
  input wire logic [SAMPLE_W-1:0] sample_ch_b,
  input wire logic [SAMPLE_W-1:0] sample_ch_c,
  input wire logic [SAMPLE_W-1:0] sample_ch_d,
  input wire logic [MAG_W-1:0] overrange_threshold,
  input wire logic overrange_detect_enable,
  input wire logic [SEL_W-1:0] overrange_hold_length_sel,
  output logic overrange_out_ch_a,
  output logic overrange_out_ch_b,
  output logic overrange_out_ch_c,
  output logic overrange_out_ch_d
);

  // ========================================================================
  // declarations
  logic [SAMPLE_W-1:0] sample_in [NUM_CH_MAX];
  logic [SAMPLE_W-1:0] sample_q [NUM_CH_MAX];
  logic [MAG_W-1:0] mag [NUM_CH_MAX];
  logic [NUM_CH_MAX-1:0] ch_active;
  logic [NUM_CH_MAX-1:0] next_hit;
  logic [NUM_CH_MAX-1:0] hit_q;
  logic [NUM_CH_MAX-1:0] pin_out;

  // ========================================================================
  // input gathering; samples come from converter logic on this clock
  assign sample_in[0] = sample_ch_a;
  assign sample_in[1] = sample_ch_b;
  assign sample_in[2] = sample_ch_c;
  assign sample_in[3] = sample_ch_d;

  // ========================================================================
  // sample capture: one register stage keeps the compare path short
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_CH_MAX; i++)
        sample_q[i] <= SAMPLE_RST;
    end
    else
    begin
      for (int i = 0; i < NUM_CH_MAX; i++)
        sample_q[i] <= sample_in[i]; // see [R1] see [R2]
    end
  end

  // ========================================================================
  // magnitude and threshold compare per channel
  // a single shared threshold keeps the comparators identical across lanes
  genvar g;
  generate
    for (g = 0; g < NUM_CH_MAX; g++)
    begin : g_ch
      assign ch_active[g] = (g < NUM_CH); // see [R8]
      assign mag[g] = ovd_magnitude(sample_q[g]); // see [R3] see [R4]
      assign next_hit[g] = overrange_detect_enable && ch_active[g]
                           && (mag[g] >= overrange_threshold); // see [R5] see [R6] see [R7]
    end
  endgenerate

  // ========================================================================
  // registered hit flags
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      hit_q <= '0;
    else
      hit_q <= next_hit;
  end

  // ========================================================================
  // hold counters; an unused lane sees enable low and so stays quiet
  generate
    for (g = 0; g < NUM_CH_MAX; g++)
    begin : g_hold
      ovd_hold_ctr u_hold (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .detect_enable(overrange_detect_enable && ch_active[g]), // see [R6] see [R8]
        .hold_length_sel(overrange_hold_length_sel),
        .hit(hit_q[g]),
        .overrange_out(pin_out[g])
      );
    end
  endgenerate

  // ========================================================================
  // pin mapping: lane a always first, so smaller variants use low pins
  assign overrange_out_ch_a = pin_out[0]; // see [R8]
  assign overrange_out_ch_b = pin_out[1];
  assign overrange_out_ch_c = pin_out[2];
  assign overrange_out_ch_d = pin_out[3];

  // ========================================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  generate
    for (g = 0; g < NUM_CH_MAX; g++)
    begin : g_chk
      // over-range seen, then two edges to the pin
      sequence s_over_seen;
        (overrange_detect_enable && ch_active[g] && mag[g] >= overrange_threshold)
          ##1 overrange_detect_enable;
      endsequence

      a_capture_sample: assert property ( // see [R1]
        ##1 (sample_q[g] == $past(sample_in[g])))
        else $error("sample not captured on the edge");

      a_mag_negative: assert property ( // see [R2]
        (sample_q[g][SAMPLE_W-1] && sample_q[g] != SAMPLE_MOST_NEG)
          |-> ((9'(mag[g]) + 9'(sample_q[g][MAG_W-1:0])) == 9'h100))
        else $error("negative magnitude is not the negated code");

      a_mag_positive: assert property ( // see [R3]
        !sample_q[g][SAMPLE_W-1] |-> (mag[g] == sample_q[g][MAG_W-1:0]))
        else $error("positive magnitude differs from code");

      a_mag_saturate: assert property ( // see [R4]
        (sample_q[g] == 9'h100) |-> (mag[g] == 8'hFF))
        else $error("most negative code did not saturate");

      a_mag_minus254: assert property ( // see [R4]
        (sample_q[g] == 9'h102) |-> (mag[g] == 8'hFE))
        else $error("code -254 did not map to 254");

      a_hit_compare: assert property ( // see [R5] see [R7]
        ##1 (hit_q[g] == $past(overrange_detect_enable && ch_active[g]
                               && mag[g] >= overrange_threshold)))
        else $error("hit flag disagrees with threshold compare");

      a_disable_quiet: assert property ( // see [R6]
        !overrange_detect_enable |=> (!hit_q[g] && !pin_out[g]))
        else $error("detection active while disabled");

      a_event_to_pin: assert property ( // see [R7]
        s_over_seen |=> pin_out[g])
        else $error("over-range did not reach the pin");

      if (g >= NUM_CH)
      begin : g_unused
        a_unused_pin: assert property ( // see [R8]
          !pin_out[g])
          else $error("unused over-range pin asserted");
      end
    end
  endgenerate

  a_pin_from_hit: assert property ( // see [R8]
    (hit_q[0] && overrange_detect_enable) |=> overrange_out_ch_a)
    else $error("lane a hit not on first pin");

endmodule

/* File: verification/ovd_gain_model.sv */
`timescale 1ns/1ps
// ==========================================================================
// downstream gain logic: suggests a threshold and times every flag pulse
module ovd_gain_model
  import ovd_pkg::*;
(
  input wire logic core_clk,
  input wire logic [NUM_CH_MAX-1:0] flags,
  output logic [MAG_W-1:0] threshold_hint,
  output logic [NUM_CH_MAX-1:0][HOLD_LEN_W-1:0] pulse_len
);
  logic [NUM_CH_MAX-1:0][HOLD_LEN_W-1:0] run_len = '0;

  // near full scale, so gain is cut before the converter clips
  assign threshold_hint = 8'hE4;

  initial pulse_len = '0;

  // length of the last finished high run per lane; 11 bits hold 1024
  always @(posedge core_clk)
    for (int i = 0; i < NUM_CH_MAX; i++)
      if (flags[i])
        run_len[i] <= run_len[i] + 11'h001;
      else if (run_len[i] != 11'h000)
      begin
        pulse_len[i] <= run_len[i];
        run_len[i] <= 11'h000;
      end
endmodule

/* File: verification/ovd_detector_tb.sv */
`timescale 1ns/1ps
// ==========================================================================
// self-checking bench for the over-range detector
module ovd_detector_tb;
  import ovd_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [SAMPLE_W-1:0] smp [4] = '{default: 9'h000};
  logic [MAG_W-1:0] thr = 8'hE4;
  logic en = 1'b0;
  logic [SEL_W-1:0] sel = 3'h0;
  logic [3:0] pin;
  logic [1:0] pin2;
  logic [NUM_CH_MAX-1:0][HOLD_LEN_W-1:0] plen;
  logic [MAG_W-1:0] thr_hint;
  int failures = 0;
  int checks_done = 0;

  // ========================================================================
  // four-lane device, a two-lane device on the same inputs, downstream logic
  ovd_detector #(.NUM_CH(4)) DUT (.core_clk(core_clk), .reset_n(reset_n),
    .sample_ch_a(smp[0]), .sample_ch_b(smp[1]), .sample_ch_c(smp[2]), .sample_ch_d(smp[3]),
    .overrange_threshold(thr), .overrange_detect_enable(en), .overrange_hold_length_sel(sel),
    .overrange_out_ch_a(pin[0]), .overrange_out_ch_b(pin[1]), .overrange_out_ch_c(pin[2]),
    .overrange_out_ch_d(pin[3]));
  ovd_detector #(.NUM_CH(2)) dut_two (.core_clk(core_clk), .reset_n(reset_n),
    .sample_ch_a(smp[0]), .sample_ch_b(smp[1]), .sample_ch_c(smp[2]), .sample_ch_d(smp[3]),
    .overrange_threshold(thr), .overrange_detect_enable(en), .overrange_hold_length_sel(sel),
    .overrange_out_ch_a(), .overrange_out_ch_b(), .overrange_out_ch_c(pin2[0]),
    .overrange_out_ch_d(pin2[1]));
  ovd_gain_model partner (.core_clk(core_clk), .flags(pin), .threshold_hint(thr_hint),
    .pulse_len(plen));

  // free-running 100 MHz clock
  initial
    forever #5 core_clk = ~core_clk;

  // ========================================================================
  // shared tasks; inputs always move 1 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_len(input string what, input logic [HOLD_LEN_W-1:0] exp,
                           input logic [HOLD_LEN_W-1:0] got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic give_verdict;
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one sample on a lane for a single cycle, then a quiet zero
  task automatic pulse(input int ch, input logic [SAMPLE_W-1:0] s);
    smp[ch] = s;
    step(1);
    smp[ch] = 9'h000;
  endtask

  // ========================================================================
  // scenarios
  // table codes at threshold equal to and one above their magnitude, where that threshold lies in 1 to 255
  task automatic test_magnitude;
    logic [SAMPLE_W-1:0] s [6] = '{9'h0FF, 9'h0FE, 9'h000, 9'h102, 9'h100, 9'h11C};
    logic [MAG_W-1:0] m [6] = '{8'hFF, 8'hFE, 8'h00, 8'hFE, 8'hFF, 8'hE4};
    int t;
    foreach (s[i])
      for (int d = 0; d < 2; d++)
      begin
        t = int'(m[i]) + d;
        if (t > 0 && t < 256)
        begin
          thr = t[MAG_W-1:0];
          pulse(0, s[i]);
          step(1);
          check_bit("lane a early", 1'b0, pin[0]);
          step(1);
          check_bit("lane a flag", d == 0, pin[0]);
          step(12);
        end
      end
  endtask

  // every length select, single event on lane b
  task automatic test_hold_lengths;
    thr = thr_hint;
    for (int k = 0; k < 8; k++)
    begin
      sel = k[SEL_W-1:0];
      pulse(1, 9'h0F0);
      step((8 << k) + 6);
      check_len("lane b pulse", HOLD_LEN_W'(8 << k), plen[1]);
    end
    sel = 3'h0;
  endtask

  // second event five cycles in restarts the hold
  task automatic test_restart;
    pulse(2, 9'h110);
    step(4);
    pulse(2, 9'h110);
    step(16);
    check_len("lane c restart", 11'h00D, plen[2]);
  endtask

  // disabled detection ignores events and kills a running hold
  task automatic test_enable;
    en = 1'b0;
    pulse(3, 9'h100);
    step(3);
    check_bit("lane d off", 1'b0, pin[3]);
    en = 1'b1;
    pulse(3, 9'h100);
    step(4);
    check_bit("lane d on", 1'b1, pin[3]);
    en = 1'b0;
    step(1);
    check_bit("lane d cleared", 1'b0, pin[3]);
    en = 1'b1;
    step(2);
  endtask

  // each lane has its own pin; unused lanes of a smaller device stay low
  task automatic test_lanes;
    smp = '{9'h100, 9'h100, 9'h100, 9'h100};
    step(1);
    smp = '{default: 9'h000};
    step(2);
    check_bit("all lanes", 1'b1, &pin);
    check_bit("spare lanes", 1'b0, |pin2);
    step(12);
    pulse(2, 9'h0FF);
    step(2);
    check_bit("lane c only", 1'b1, pin == 4'h4);
    check_bit("spare lane c", 1'b0, pin2[0]);
    step(12);
  endtask

  // ========================================================================
  // main sequence
  initial
  begin
    step(20);
    reset_n = 1'b1;
    check_bit("pins in reset", 1'b0, |pin);
    step(3);
    en = 1'b1;
    test_magnitude();
    test_hold_lengths();
    test_restart();
    test_enable();
    test_lanes();
    give_verdict();
  end

  // watchdog: the run needs well under 5000 cycles
  initial
  begin
    #100000;
    failures++;
    give_verdict();
  end
endmodule
